// >>> rtl/eeprom_ctrl_pkg.sv
// Constants and types shared by the serial EEPROM protection and pause control
package eeprom_ctrl_pkg;

   // Instruction byte layout: upper nibble zero, low three bits select the operation
   localparam logic [3:0] CMD_HI_NIBBLE         = 4'h0;
   localparam logic [2:0] OP_WRITE              = 3'h2;
   localparam logic [2:0] OP_READ               = 3'h3;
   localparam logic [2:0] OP_CLEAR_WRITE_LATCH  = 3'h4;
   localparam logic [2:0] OP_SET_WRITE_LATCH    = 3'h6;
   localparam logic [2:0] OP_READ_STATUS        = 3'h5;
   localparam logic [2:0] OP_WRITE_STATUS       = 3'h1;
   localparam int         CMD_A8_POS            = 3;

   // Bit counts that make a sequence complete, the counter ceiling, and the last bit of each captured byte
   localparam logic [7:0] BITS_LATCH_CMD        = 8'h08;
   localparam logic [7:0] BITS_STATUS_WRITE     = 8'h10;
   localparam logic [7:0] BITS_WRITE_MIN        = 8'h18;
   localparam logic [7:0] BITS_SAT              = 8'hFF;
   localparam logic [7:0] BIT_LAST_CMD          = 8'h07;
   localparam logic [7:0] BIT_LAST_BYTE2        = 8'h0F;

   // Status register bit positions
   localparam int         STAT_BUSY_POS         = 0;
   localparam int         STAT_LATCH_POS        = 1;
   localparam int         STAT_BP_LO_POS        = 2;
   localparam int         STAT_BP_HI_POS        = 3;

   // Protection codes and the first protected address of each
   localparam logic [1:0] BP_NONE               = 2'h0;
   localparam logic [1:0] BP_QUARTER            = 2'h1;
   localparam logic [1:0] BP_HALF               = 2'h2;
   localparam logic [8:0] PROT_QUARTER_BASE     = 9'h180;
   localparam logic [8:0] PROT_HALF_BASE        = 9'h100;

   // Values after reset
   localparam logic [1:0] BP_RESET              = 2'h0;
   localparam logic       LATCH_RESET           = 1'b0;

   // Self-timed write cycle, longest time rounded down to clock cycles
   localparam int         CLK_PERIOD_NS         = 10;
   localparam int         WRITE_CYCLE_NS        = 5000000;
   localparam int         WRITE_CYCLE_CYCLES    = WRITE_CYCLE_NS / CLK_PERIOD_NS;
   localparam int         TIMER_W               = 19;

   // Kind of internal write being run
   typedef enum logic [1:0] {
      WK_NONE,
      WK_STATUS,
      WK_ARRAY
   } write_kind_t;

endpackage

// >>> rtl/spi_eeprom_protect_hold_ctrl.sv
// Serial EEPROM write-protection, write latch, self-timed cycle and pause control
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Status write changes only the two block-protection bits.
// RULE_02 - Protection 00 none, 01 180h-1FFh, 10 100h-1FFh, 11 everything.
// RULE_03 - Valid status write starts the internal cycle at chip select rising.
// RULE_04 - Write latch is cleared at power-up.
// RULE_05 - Write latch clears automatically when any write cycle completes.
// RULE_06 - Write starts only when select rises after exactly the right bit count.
// RULE_07 - Array accesses during an internal write are ignored.
// RULE_08 - Power-up in standby, output off; select must fall before a sequence.
// RULE_09 - Write-protect low refuses array and status writes, others run.
// RULE_10 - Writes need protect high and latch set; protected blocks never written.
// RULE_11 - Write-protect low holds the latch cleared and blocks programming.
// RULE_12 - Write-protect falling during a cycle does not disturb that cycle.
// RULE_13 - Deselect enters standby only after a started cycle finishes.
// RULE_14 - Deselected device floats its serial output.
// RULE_15 - Serial input sampled on each rising serial clock edge.
// RULE_16 - Serial output changes after each falling serial clock edge.
// RULE_17 - Pause low mid-sequence freezes the sequence without resetting it.
// RULE_18 - Pause lowered while clock high takes effect at the next falling edge.
// RULE_19 - While paused, serial input, clock and output transitions are ignored.
// RULE_20 - Resume needs pause raised while the serial clock is low.
// RULE_21 - Pause low always floats the serial output.
// RULE_22 - Master keeps the pause input high when unused.
// RULE_23 - Status readable anytime: bit0 busy, bit1 latch, bits 3:2 protection.
// RULE_24 - Set-latch command sets the latch, clear-latch command clears it.
// RULE_25 - Status write is command then data byte, MSB first, bits 3:2 used.
module spi_eeprom_protect_hold_ctrl #(
   parameter int unsigned WRITE_CYCLE_LEN = eeprom_ctrl_pkg::WRITE_CYCLE_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       si,
   input  wire logic       hold_n,
   input  wire logic       wp_n,
   output logic            so_o,
   output logic            so_oe,
   output logic            write_busy_flag,
   output logic            write_latch_flag,
   output logic            block_protect_hi,
   output logic            block_protect_lo,
   output logic            arr_prog_start,
   output logic [8:0]      arr_prog_addr
);

   // Link-domain state, clocked by the rising serial clock
   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] cmd;
      logic [7:0] shreg;
      logic [7:0] byte2;
      logic [3:0] stat_s1;
      logic [3:0] stat_s2;
   } link_t;

   // Core state, clocked by ref_clk
   typedef struct packed {
      logic [1:0]                          cs_sync;
      logic [1:0]                          hold_sync;
      logic [1:0]                          wp_sync;
      logic                                cs_prev;
      logic                                busy;
      logic [eeprom_ctrl_pkg::TIMER_W-1:0] timer;
      eeprom_ctrl_pkg::write_kind_t        kind;
      logic                                latch;
      logic [1:0]                          bp;
      logic [1:0]                          bp_pend;
      logic                                oe;
      logic                                prog;
      logic [8:0]                          addr;
   } core_t;

   link_t link_q;
   link_t link_d;
   core_t core_q;
   core_t core_d;
   logic  frame_new_q;
   logic  so_q;

   // Frame start marker: raised while deselected, dropped by the first clock
   always_ff @(posedge sck or posedge cs_n or negedge nrst) begin
      if (!nrst) begin
         frame_new_q <= 1'b1;
      end else if (cs_n) begin
         frame_new_q <= 1'b1;
      end else begin
         frame_new_q <= 1'b0;
      end
   end

   // Shifter and bit counter; pause gates every clock edge out
   always_comb begin
      logic [7:0] base;
      logic [7:0] sh_new;
      base   = 8'h00;
      sh_new = 8'h00;
      link_d = link_q;
      link_d.stat_s1 = {core_q.bp, core_q.latch, core_q.busy};
      link_d.stat_s2 = link_q.stat_s1;
      base   = frame_new_q ? 8'h00 : link_q.cnt;
      sh_new = {link_q.shreg[6:0], si};                          // RULE_15
      if (hold_n) begin                                          // RULE_17 RULE_19
         link_d.shreg = sh_new;                                  // RULE_25
         link_d.cnt   = (base == eeprom_ctrl_pkg::BITS_SAT) ? base : base + 8'h01;
         if (base == eeprom_ctrl_pkg::BIT_LAST_CMD) begin
            link_d.cmd = sh_new;
         end
         if (base == eeprom_ctrl_pkg::BIT_LAST_BYTE2) begin
            link_d.byte2 = sh_new;
         end
      end else begin
         link_d.cnt = base;
      end
   end

   always_ff @(posedge sck or negedge nrst) begin
      if (!nrst) begin
         link_q <= '0;
      end else begin
         link_q <= link_d;
      end
   end

   // Status shifted out MSB first on falling edges; frozen while paused
   always_ff @(negedge sck or negedge nrst) begin
      if (!nrst) begin
         so_q <= 1'b0;
      end else if (hold_n) begin                                 // RULE_18 RULE_19
         if (link_q.cmd[7:4] == eeprom_ctrl_pkg::CMD_HI_NIBBLE &&
             link_q.cmd[2:0] == eeprom_ctrl_pkg::OP_READ_STATUS &&
             link_q.cnt >= eeprom_ctrl_pkg::BITS_LATCH_CMD) begin
            so_q <= (3'h7 - link_q.cnt[2:0] > 3'h3) ? 1'b0 :    // RULE_16 RULE_23
                    link_q.stat_s2[2'(3'h7 - link_q.cnt[2:0])];
         end else begin
            so_q <= 1'b0;
         end
      end
   end

   assign so_o = so_q;

   // Sequence decode, valid only once select has risen and the clock is idle
   logic        cs_rise;
   logic        cmd_ok;
   logic        is_set_write_latch_cmd;
   logic        is_clear_write_latch_cmd;
   logic        is_write_status_cmd;
   logic        is_write;
   logic [8:0]  wr_addr;
   logic        addr_prot;
   logic        wr_allow;

   assign cs_rise  = core_q.cs_sync[1] & ~core_q.cs_prev;
   assign cmd_ok   = link_q.cmd[7:4] == eeprom_ctrl_pkg::CMD_HI_NIBBLE;
   // Exact bit counts for latch and status commands, whole bytes from 24 to 248 bits for writes; anything else discards the sequence
   assign is_set_write_latch_cmd  = cmd_ok && link_q.cmd[2:0] == eeprom_ctrl_pkg::OP_SET_WRITE_LATCH &&
                     link_q.cnt == eeprom_ctrl_pkg::BITS_LATCH_CMD;     // RULE_06
   assign is_clear_write_latch_cmd  = cmd_ok && link_q.cmd[2:0] == eeprom_ctrl_pkg::OP_CLEAR_WRITE_LATCH &&
                     link_q.cnt == eeprom_ctrl_pkg::BITS_LATCH_CMD;     // RULE_06
   assign is_write_status_cmd  = cmd_ok && link_q.cmd[2:0] == eeprom_ctrl_pkg::OP_WRITE_STATUS &&
                     link_q.cnt == eeprom_ctrl_pkg::BITS_STATUS_WRITE;  // RULE_06
   assign is_write = cmd_ok && link_q.cmd[2:0] == eeprom_ctrl_pkg::OP_WRITE &&
                     link_q.cnt >= eeprom_ctrl_pkg::BITS_WRITE_MIN &&
                     link_q.cnt != eeprom_ctrl_pkg::BITS_SAT &&
                     link_q.cnt[2:0] == 3'h0;                           // RULE_06
   assign wr_addr  = {link_q.cmd[eeprom_ctrl_pkg::CMD_A8_POS], link_q.byte2};

   // Block protection decode; pages never straddle a protection boundary
   always_comb begin
      unique case (core_q.bp)                                    // RULE_02
         eeprom_ctrl_pkg::BP_NONE:    addr_prot = 1'b0;
         eeprom_ctrl_pkg::BP_QUARTER: addr_prot = wr_addr >= eeprom_ctrl_pkg::PROT_QUARTER_BASE;
         eeprom_ctrl_pkg::BP_HALF:    addr_prot = wr_addr >= eeprom_ctrl_pkg::PROT_HALF_BASE;
         default:                     addr_prot = 1'b1;
      endcase
   end

   // Write permission: protect pin high, latch set, idle
   assign wr_allow = core_q.wp_sync[1] & core_q.latch & ~core_q.busy;   // RULE_09 RULE_10

   // Last timer value of a self-timed cycle; the cycle lasts WRITE_CYCLE_LEN clocks
   localparam logic [eeprom_ctrl_pkg::TIMER_W-1:0] TIMER_LAST =
      eeprom_ctrl_pkg::TIMER_W'(WRITE_CYCLE_LEN - 1);

   // Core next state
   always_comb begin
      core_d = core_q;
      core_d.cs_sync   = {core_q.cs_sync[0], cs_n};
      core_d.hold_sync = {core_q.hold_sync[0], hold_n};
      core_d.wp_sync   = {core_q.wp_sync[0], wp_n};
      core_d.cs_prev   = core_q.cs_sync[1];
      core_d.prog      = 1'b0;
      // Output only while selected and not paused
      core_d.oe        = ~core_q.cs_sync[1] & core_q.hold_sync[1];      // RULE_14 RULE_21
      // Running cycle finishes regardless of select or protect pin
      if (core_q.busy) begin                                     // RULE_12 RULE_13
         if (core_q.timer == TIMER_LAST) begin
            core_d.busy  = 1'b0;
            core_d.timer = '0;
            core_d.latch = 1'b0;                                 // RULE_05
            if (core_q.kind == eeprom_ctrl_pkg::WK_STATUS) begin
               core_d.bp = core_q.bp_pend;                       // RULE_01
            end
            core_d.kind = eeprom_ctrl_pkg::WK_NONE;
         end else begin
            core_d.timer = core_q.timer + 1'b1;
         end
      end
      // Completed sequences; busy device ignores all writing commands
      if (cs_rise && !core_q.busy) begin                         // RULE_07
         if (is_set_write_latch_cmd) begin
            core_d.latch = 1'b1;                                 // RULE_24
         end else if (is_clear_write_latch_cmd) begin
            core_d.latch = 1'b0;                                 // RULE_24
         end else if (is_write_status_cmd && wr_allow) begin
            core_d.busy    = 1'b1;                               // RULE_03
            core_d.kind    = eeprom_ctrl_pkg::WK_STATUS;
            core_d.bp_pend = link_q.byte2[eeprom_ctrl_pkg::STAT_BP_HI_POS:
                                          eeprom_ctrl_pkg::STAT_BP_LO_POS];  // RULE_25
         end else if (is_write && wr_allow && !addr_prot) begin  // RULE_10
            core_d.busy = 1'b1;
            core_d.kind = eeprom_ctrl_pkg::WK_ARRAY;
            core_d.prog = 1'b1;
            core_d.addr = wr_addr;
         end
      end
      // Protect pin low forces the latch clear, overriding a set
      if (!core_q.wp_sync[1]) begin
         core_d.latch = 1'b0;                                    // RULE_11
      end
   end

   // Power-up state: standby, output off, latch clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         core_q <= '{cs_sync: 2'h3, hold_sync: 2'h3, wp_sync: 2'h0,  // RULE_08
                     cs_prev: 1'b1, busy: 1'b0, timer: '0,
                     kind: eeprom_ctrl_pkg::WK_NONE,
                     latch: eeprom_ctrl_pkg::LATCH_RESET,         // RULE_04
                     bp: eeprom_ctrl_pkg::BP_RESET, bp_pend: eeprom_ctrl_pkg::BP_RESET,
                     oe: 1'b0, prog: 1'b0, addr: 9'h000};
      end else begin
         core_q <= core_d;
      end
   end

   assign so_oe            = core_q.oe;
   assign write_busy_flag  = core_q.busy;
   assign write_latch_flag = core_q.latch;
   assign block_protect_hi = core_q.bp[1];
   assign block_protect_lo = core_q.bp[0];
   assign arr_prog_start   = core_q.prog;
   assign arr_prog_addr    = core_q.addr;

   // Checks on the core domain
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   wp_clears_latch_a: assert property (!core_q.wp_sync[1] |=> !write_latch_flag) // RULE_11
      else $error("latch set while protect pin low");
   done_clears_latch_a: assert property ($fell(write_busy_flag) |-> !write_latch_flag) // RULE_05
      else $error("latch still set after write cycle");
   bp_only_write_status_cmd_a: assert property ($changed(core_q.bp) |-> $fell(write_busy_flag) &&
                                    $past(core_q.kind) == eeprom_ctrl_pkg::WK_STATUS) // RULE_01
      else $error("protection bits changed outside status write");
   busy_from_cs_a: assert property ($rose(write_busy_flag) |-> $past(cs_rise)) // RULE_03
      else $error("write cycle started without select rising");
   prog_needs_latch_a: assert property (arr_prog_start |-> $past(write_latch_flag) &&
                                        $past(core_q.wp_sync[1]) && write_busy_flag) // RULE_10
      else $error("array write started without permission");
   busy_no_restart_a: assert property ($past(write_busy_flag) |-> !arr_prog_start) // RULE_07
      else $error("array write accepted during busy cycle");
   oe_off_deselect_a: assert property (core_q.cs_sync[1] |=> !so_oe) // RULE_14
      else $error("output driven while deselected");
   oe_off_hold_a: assert property (!core_q.hold_sync[1] |=> !so_oe) // RULE_21
      else $error("output driven while paused");
   prot_range_a: assert property (arr_prog_start && core_q.bp == eeprom_ctrl_pkg::BP_QUARTER
                                  |-> arr_prog_addr < eeprom_ctrl_pkg::PROT_QUARTER_BASE) // RULE_02
      else $error("write into protected quarter");
   wp_low_busy_a: assert property (write_busy_flag && !core_q.wp_sync[1] &&
                                   core_q.timer != TIMER_LAST |=> write_busy_flag) // RULE_12
      else $error("write cycle cut short by protect pin");
   clear_write_latch_cmd_clears_a: assert property (cs_rise && is_clear_write_latch_cmd && !write_busy_flag
                                   |=> !write_latch_flag) // RULE_24
      else $error("clear-latch command did not clear");

   // Cycle starts only with the protect pin high
   wp_refuse_a: assert property ($rose(write_busy_flag)
                                 |-> $past(core_q.wp_sync[1])) // RULE_09
      else $error("write cycle started while protect pin low");

   // Cycle starts only with the latch set
   start_latch_a: assert property ($rose(write_busy_flag)
                                   |-> $past(write_latch_flag)) // RULE_10
      else $error("write cycle started with latch clear");

   // Whole array protected: no array write may start
   full_prot_a: assert property (arr_prog_start |-> core_q.bp != 2'h3) // RULE_02
      else $error("write started with whole array protected");

   // Upper half protected: only lower addresses may start
   half_prot_a: assert property (arr_prog_start && core_q.bp == eeprom_ctrl_pkg::BP_HALF
                                 |-> arr_prog_addr < eeprom_ctrl_pkg::PROT_HALF_BASE) // RULE_02
      else $error("write into protected half");

   // Start strobe lasts a single cycle
   prog_pulse_a: assert property (arr_prog_start |=> !arr_prog_start) // RULE_07
      else $error("array start strobe longer than one cycle");

   // Start address moves only together with the strobe
   addr_hold_a: assert property (!arr_prog_start |-> $stable(arr_prog_addr)) // RULE_10
      else $error("array address changed without a start");

   // A started cycle keeps running for at least 8 cycles whatever select does
   busy_min_a: assert property ($rose(write_busy_flag)
                                |-> write_busy_flag [*8]) // RULE_13
      else $error("write cycle ended too early");

   // Set-latch command has no effect while a cycle runs
   busy_latch_a: assert property ($past(write_busy_flag)
                                  |-> !$rose(write_latch_flag)) // RULE_07
      else $error("latch set during busy cycle");

   status_write_c: cover property ($fell(write_busy_flag) &&
                                   $past(core_q.kind) == eeprom_ctrl_pkg::WK_STATUS);
   array_write_c:  cover property (arr_prog_start);
   latch_set_c:    cover property ($rose(write_latch_flag));
   wp_block_c:     cover property (cs_rise && is_write_status_cmd && !core_q.wp_sync[1]);
   // Pause taken while selected
   hold_c:         cover property (!core_q.hold_sync[1] && !core_q.cs_sync[1]);

endmodule

// >>> bench/spi_master_model.sv
// SPI bus master model driving select, clock, data and pause
`timescale 1ns/1ps
module spi_master_model (
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   output logic      hold_n,
   input  wire logic so_o
);
   // Idle bus: deselected, clock parked low, pause released
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
   end

   // One framed transfer, MSB first, optional pause before bit hold_at
   task automatic frame(input logic [31:0] d, input int n, input int hold_at,
                        output logic [7:0] rd);
      rd = 8'h00;
      cs_n = 1'b0;
      #37;
      for (int j = 0; j < n; j++) begin
         if (j == hold_at) begin
            hold_n = 1'b0;
            // Clock and data wiggle while paused
            repeat (3) begin
               #15 sck = 1'b1;
               si = ~si;
               #15 sck = 1'b0;
            end
            hold_n = 1'b1;
            #7;
         end
         si = d[n-1-j];
         #15 sck = 1'b1;
         rd = {rd[6:0], so_o};
         #15 sck = 1'b0;
      end
      #15 cs_n = 1'b1;
      si = ~si; // Released line shows no stale value
   endtask
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the EEPROM protection, write cycle and pause control
`timescale 1ns/1ps
module testbench;
   localparam int WLEN = 150;
   logic       ref_clk, nrst, wp_n, sck, cs_n, si, hold_n;
   logic       so_o, so_oe, busy, latch, bp_hi, bp_lo, prog;
   logic [8:0] prog_addr, last_addr;
   logic [7:0] rd;
   int         num_errors, n_tests, busy_cnt, prog_cnt, hold_cnt;

   spi_eeprom_protect_hold_ctrl #(.WRITE_CYCLE_LEN(WLEN)) dut (
      .ref_clk(ref_clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
      .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe),
      .write_busy_flag(busy), .write_latch_flag(latch), .block_protect_hi(bp_hi),
      .block_protect_lo(bp_lo), .arr_prog_start(prog), .arr_prog_addr(prog_addr));

   spi_master_model m (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o));

   // Core clock
   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   task automatic end_sim();
      $display("errors %0d comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Busy length, start pulses, output float when paused or deselected
   always @(posedge ref_clk) begin
      if (busy === 1'b1) busy_cnt++;
      if (prog === 1'b1) begin
         prog_cnt++;
         last_addr = prog_addr;
      end
      hold_cnt = (hold_n && !cs_n) ? 0 : hold_cnt + 1;
      if (hold_cnt > 5) chk(so_oe, 1'b0);
   end

   task automatic wait_idle();
      int k;
      k = 0;
      repeat (8) @(posedge ref_clk);
      while (busy !== 1'b0 && k < 400) begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 400) begin
         num_errors++;
         end_sim();
      end
      #1;
   endtask

   task automatic run(input logic [31:0] d, input int n, input int h, input int blen);
      busy_cnt = 0;
      prog_cnt = 0;
      m.frame(d, n, h, rd);
      wait_idle();
      chk(16'(busy_cnt), 16'(blen));
   endtask

   task automatic flags(input logic [1:0] bpe, input logic le);
      chk({bp_hi, bp_lo, latch, busy}, {bpe, le, 1'b0});
      m.frame(32'h0500, 16, -1, rd);
      chk(rd, {4'h0, bpe, le, 1'b0});
      #100;
   endtask

   task automatic setbp(input logic [1:0] c);
      run(32'h06, 8, -1, 0);
      run({16'h0, 8'h01, 4'h0, c, 2'h0}, 16, -1, WLEN);
   endtask

   task automatic t_latch();
      chk(so_oe, 1'b0);
      flags(2'h0, 1'b0);
      run(32'h06, 8, -1, 0);
      flags(2'h0, 1'b1);
      run(32'h04, 8, -1, 0);
      flags(2'h0, 1'b0);
      run(32'h0C, 9, -1, 0);
      flags(2'h0, 1'b0);
   endtask

   task automatic t_stat();
      for (int i = 1; i < 5; i++) begin
         run(32'h06, 8, -1, 0);
         run({16'h0, 8'h01, 4'hF, 2'(i), 2'h3}, 16, -1, WLEN);
         flags(2'(i), 1'b0);
      end
      run(32'h06, 8, -1, 0);
      run(32'h0086, 15, -1, 0);
      run(32'h00218, 17, -1, 0);
      flags(2'h0, 1'b1);
      run(32'h04, 8, -1, 0);
   endtask

   task automatic t_wp();
      @(posedge ref_clk) #1 wp_n = 1'b0;
      run(32'h06, 8, -1, 0);
      flags(2'h0, 1'b0);
      @(posedge ref_clk) #1 wp_n = 1'b1;
      run(32'h0128, 16, -1, 0);
      run(32'h06, 8, -1, 0);
      @(posedge ref_clk) #1 wp_n = 1'b0;
      repeat (6) @(posedge ref_clk);
      chk(latch, 1'b0);
      run(32'h0128, 16, -1, 0);
      flags(2'h0, 1'b0);
      @(posedge ref_clk) #1 wp_n = 1'b1;
   endtask

   task automatic t_array();
      logic [8:0] a;
      logic       ok;
      for (int c = 0; c < 4; c++) begin
         setbp(2'(c));
         for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 9'h0FF : (i == 1) ? 9'h100 : (i == 2) ? 9'h17F : 9'h180;
            ok = (c == 0) || (c == 1 && a < 9'h180) || (c == 2 && a < 9'h100);
            run(32'h06, 8, -1, 0);
            run({8'h0, 4'h0, a[8], 3'h2, a[7:0], 8'hA5}, 24, -1, ok ? WLEN : 0);
            chk(16'(prog_cnt), 16'(ok));
            if (ok) chk(last_addr, a);
            run(32'h04, 8, -1, 0);
         end
      end
      setbp(2'h0);
   endtask

   task automatic t_busy();
      run(32'h06, 8, -1, 0);
      busy_cnt = 0;
      prog_cnt = 0;
      m.frame(32'h0210A5, 24, -1, rd);
      #100;
      m.frame(32'h0500, 16, -1, rd);
      chk(rd, 8'h03);
      #100;
      m.frame(32'h06, 8, -1, rd);
      @(posedge ref_clk) #1 wp_n = 1'b0;
      wait_idle();
      chk(16'(busy_cnt), 16'(WLEN));
      chk(16'(prog_cnt), 16'h1);
      chk(latch, 1'b0);
      @(posedge ref_clk) #1 wp_n = 1'b1;
   endtask

   task automatic t_hold();
      run(32'h06, 8, -1, 0);
      run(32'h0108, 16, 5, WLEN);
      m.frame(32'h0500, 16, 11, rd);
      chk(rd, 8'h08);
      #100;
      setbp(2'h0);
   endtask

   // Reset, then every scenario in turn
   initial begin
      nrst = 1'b0;
      wp_n = 1'b1;
      num_errors = 0;
      n_tests = 0;
      busy_cnt = 0;
      prog_cnt = 0;
      hold_cnt = 0;
      repeat (3) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge ref_clk);
      t_latch();
      t_stat();
      t_wp();
      t_array();
      t_busy();
      t_hold();
      end_sim();
   end
endmodule
